// ### verilog/rsps_pkg.sv
// Package for the ramp and soak profile sequencer: register map, field
// positions, reset values, time base and the shared types.
// Assumes a 32-bit APB slave port and a 25 MHz system clock.
package rsps_pkg;
    localparam int          RSPS_NUM_PROFILES = 7;
    localparam int          RSPS_NUM_SEGS     = 7;
    localparam int          RSPS_SP_W         = 16;
    localparam int          RSPS_DUR_W        = 12;
    localparam int          RSPS_EVT_W        = 4;
    localparam int          RSPS_MEM_AW       = 6;

    // Register byte offsets
    localparam logic [11:0] RSPS_OFF_CTRL     = 12'h000;
    localparam logic [11:0] RSPS_OFF_TOL      = 12'h004;
    localparam logic [11:0] RSPS_OFF_LINK     = 12'h008;
    localparam logic [11:0] RSPS_OFF_ALCFG    = 12'h00c;
    localparam logic [11:0] RSPS_OFF_STATUS   = 12'h010;
    localparam logic [11:0] RSPS_OFF_IRQ_STAT = 12'h014;
    localparam logic [11:0] RSPS_OFF_IRQ_MASK = 12'h018;
    localparam logic [11:0] RSPS_OFF_SP       = 12'h01c;
    localparam logic [11:0] RSPS_OFF_ELAPSED  = 12'h020;
    localparam logic [11:0] RSPS_OFF_SEG_BASE = 12'h100;
    localparam logic [11:0] RSPS_OFF_SEG_END  = 12'h1e0;

    // Control register fields
    localparam int          RSPS_CTRL_AUTO    = 0;
    localparam int          RSPS_CTRL_PEN     = 1;
    localparam int          RSPS_CTRL_RUN     = 2;
    localparam int          RSPS_CTRL_SEL     = 4;

    // Interrupt status bits
    localparam int          RSPS_IRQ_SEG_DONE = 0;
    localparam int          RSPS_IRQ_PROG_END = 1;
    localparam int          RSPS_IRQ_CHAIN    = 2;
    localparam int          RSPS_IRQ_HOLD     = 3;
    localparam int          RSPS_IRQ_W        = 4;

    // Word 7 of each profile slot holds the initial setpoint
    localparam logic [2:0]  RSPS_INIT_IDX     = 3'h7;
    localparam logic [2:0]  RSPS_NO_LINK      = 3'h0;

    localparam logic [15:0] RSPS_TOL_RST      = 16'h0000;
    localparam logic [20:0] RSPS_LINK_RST     = 21'h000000;

    // Time base: one segment time unit in ms, converted to clock cycles
    localparam int          RSPS_CLK_HZ       = 25000000;
    localparam int          RSPS_TIME_UNIT_MS = 1000;
    localparam int          RSPS_TICK_CYC_DEF = RSPS_CLK_HZ / 1000 * RSPS_TIME_UNIT_MS;

    typedef enum logic [2:0] {
        ST_IDLE, ST_LOAD_INIT, ST_INIT_W, ST_WAIT_PV,
        ST_LOAD_SEG, ST_SEG_W, ST_RUN, ST_PFAIL
    } rsps_mode_t;

    typedef struct packed {
        logic [RSPS_EVT_W-1:0] evt;
        logic [RSPS_DUR_W-1:0] dur;
        logic [RSPS_SP_W-1:0]  sp;
    } rsps_seg_t;
endpackage : rsps_pkg

// ### verilog/rsps_seg_mem.sv
// Segment store for the profile sequencer: one write port, one read
// port whose data come out of a register one cycle after the address.
// Assumes the writer and reader share the system clock.
`timescale 1ns/1ps
module rsps_seg_mem import rsps_pkg::*; #(
    parameter int DW = 32,
    parameter int AW = RSPS_MEM_AW
) (
    input  wire logic          clk_in,
    input  wire logic          we_in,
    input  wire logic [AW-1:0] waddr_in,
    input  wire logic [DW-1:0] wdata_in,
    input  wire logic [AW-1:0] raddr_in,
    output logic      [DW-1:0] rdata_out
);
    logic [DW-1:0] mem_q [0:(1<<AW)-1];

    // No reset on the array: contents are undefined until software loads them
    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem_q[waddr_in] <= wdata_in;
        end
        rdata_out <= mem_q[raddr_in];
    end
endmodule : rsps_seg_mem

// ### verilog/rsps_tick.sv
// Time base for the profile sequencer: one-cycle pulse every CYCLES clocks.
// Assumes a free-running system clock and asynchronous active-low reset.
`timescale 1ns/1ps
module rsps_tick #(
    parameter int CYCLES = 25000000
) (
    input  wire logic clk_in,
    input  wire logic arst_n_in,
    output logic      tick_out
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_q;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_q    <= '0;
            tick_out <= 1'b0;
        end else begin
            tick_out <= (cnt_q == LAST);
            cnt_q    <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
        end
    end
endmodule : rsps_tick

// ### verilog/rsps_top.sv
// Ramp and soak profile sequencer with APB register access.
// Assumes PV_IN and PWR_FAIL_IN are synchronous to CLK_SYS_IN.
// How it works
// - Each profile holds up to seven segments, each a setpoint with a time interval.
// - Seven independent profiles are stored and any one can be selected to run.
// - When an unlinked profile ends, the run control is cleared so control stops.
// - A segment with zero duration ends the profile.
// - With nonzero tolerance the segment timer stops while deviation exceeds it.
// - With zero tolerance the timer advances on time alone, ignoring deviation.
// - A linked profile starts its target profile at once when it finishes.
// - Linking a profile to itself or closing a chain repeats it without end.
// - Each segment drives the alarms its event setting selects, if set up as event alarms.
// - After start the first segment waits until the process value reaches the initial setpoint.
// - After power returns the interrupted segment restarts from its beginning.
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module rsps_top import rsps_pkg::*; #(
    parameter int TICK_CYCLES = RSPS_TICK_CYC_DEF
) (
    input  wire logic        CLK_SYS_IN,
    input  wire logic        ARST_N_IN,
    input  wire logic        APB_PSEL_IN,
    input  wire logic        APB_PENABLE_IN,
    input  wire logic        APB_PWRITE_IN,
    input  wire logic [11:0] APB_PADDR_IN,
    input  wire logic [31:0] APB_PWDATA_IN,
    output logic             APB_PREADY_OUT,
    output logic      [31:0] APB_PRDATA_OUT,
    output logic             APB_PSLVERR_OUT,
    input  wire logic [15:0] PV_IN,
    input  wire logic        PWR_FAIL_IN,
    output logic      [15:0] SP_OUT,
    output logic             CTRL_RUN_OUT,
    output logic             PROG_ACTIVE_OUT,
    output logic      [3:0]  ALARM_OUT,
    output logic             IRQ_OUT
);
    typedef struct packed {
        rsps_mode_t      mode;
        logic            ctl_auto;
        logic            ctl_pen;
        logic            ctl_run;
        logic [2:0]      sel;
        logic [15:0]     tol;
        logic [20:0]     link;
        logic [3:0]      alcfg;
        logic [3:0]      irq_stat;
        logic [3:0]      irq_mask;
        logic [2:0]      prof;
        logic [2:0]      seg;
        logic [11:0]     elapsed;
        logic [15:0]     start_sp;
        rsps_seg_t       cur;
        logic [15:0]     sp;
        logic [3:0]      alarm;
        logic            chain;
        logic            below;
        logic            hold;
        logic [31:0]     prdata;
        logic            slverr;
    } rsps_state_t;

    rsps_state_t st_q;
    rsps_state_t st_d;
    rsps_seg_t   rd_seg;
    logic [31:0] rd_word;
    logic        tick;
    logic        mem_we;
    logic [5:0]  mem_raddr;
    logic        go;
    logic        hold_now;
    logic        reached;
    logic [2:0]  linkv;
    logic        wr_acc;
    logic        setup;
    logic        seg_win;

    function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
        logic signed [16:0] d;
        d = $signed({a[15], a}) - $signed({b[15], b});
        abs_diff = d[16] ? 16'(-d) : d[15:0];
    endfunction : abs_diff

    function automatic logic [15:0] ramp_point(input logic [15:0] a, input logic [15:0] b,
                                               input logic [11:0] t, input logic [11:0] dur);
        logic signed [16:0] delta;
        logic signed [29:0] prod;
        logic signed [29:0] q;
        delta = $signed({b[15], b}) - $signed({a[15], a});
        prod  = delta * $signed({1'b0, t});
        q     = (dur == 12'h000) ? 30'sh0 : prod / $signed({18'h00000, dur});
        ramp_point = a + q[15:0];
    endfunction : ramp_point

    rsps_tick #(.CYCLES(TICK_CYCLES)) u_tick (
        .clk_in    (CLK_SYS_IN),
        .arst_n_in (ARST_N_IN),
        .tick_out  (tick)
    );

    assign setup   = APB_PSEL_IN && !APB_PENABLE_IN;
    assign wr_acc  = APB_PSEL_IN && APB_PENABLE_IN && APB_PWRITE_IN;
    assign seg_win = (APB_PADDR_IN >= RSPS_OFF_SEG_BASE) && (APB_PADDR_IN < RSPS_OFF_SEG_END);
    assign mem_we  = wr_acc && seg_win && (APB_PADDR_IN[1:0] == 2'h0);

    // Read port is owned by the sequencer; segment words are write-only on the bus
    assign mem_raddr = (st_q.mode == ST_LOAD_INIT) ? {st_q.prof, RSPS_INIT_IDX}
                                                  : {st_q.prof, st_q.seg};

    rsps_seg_mem #(.DW(32), .AW(RSPS_MEM_AW)) u_mem (
        .clk_in    (CLK_SYS_IN),
        .we_in     (mem_we),
        .waddr_in  (APB_PADDR_IN[7:2]),
        .wdata_in  (APB_PWDATA_IN),
        .raddr_in  (mem_raddr),
        .rdata_out (rd_word)
    );
    assign rd_seg = rsps_seg_t'(rd_word);

    assign go = st_q.ctl_auto && st_q.ctl_pen && st_q.ctl_run && (st_q.sel != 3'h0);
    assign hold_now = (st_q.tol != 16'h0000) && (abs_diff(PV_IN, st_q.sp) > st_q.tol);
    assign reached  = st_q.below ? ($signed(PV_IN) >= $signed(st_q.start_sp))
                                 : ($signed(PV_IN) <= $signed(st_q.start_sp));
    assign linkv    = st_q.link[int'(st_q.prof) * 3 +: 3];

    always_comb begin
        logic [3:0] ev;
        logic [3:0] w1c;
        logic [11:0] nxt;
        ev  = 4'h0;
        w1c = 4'h0;
        nxt = st_q.elapsed + 12'h001;
        st_d = st_q;

        // Register setup: read data and error are latched for the access phase
        if (setup) begin
            st_d.prdata = 32'h00000000;
            st_d.slverr = 1'b0;
            if (APB_PADDR_IN == RSPS_OFF_CTRL) begin
                st_d.prdata = {25'h0, st_q.sel, 1'b0, st_q.ctl_run, st_q.ctl_pen, st_q.ctl_auto};
            end else if (APB_PADDR_IN == RSPS_OFF_TOL) begin
                st_d.prdata = {16'h0000, st_q.tol};
            end else if (APB_PADDR_IN == RSPS_OFF_LINK) begin
                st_d.prdata = {11'h000, st_q.link};
            end else if (APB_PADDR_IN == RSPS_OFF_ALCFG) begin
                st_d.prdata = {28'h0000000, st_q.alcfg};
            end else if (APB_PADDR_IN == RSPS_OFF_STATUS) begin
                st_d.prdata = {17'h00000, st_q.mode, st_q.hold, st_q.chain,
                               st_q.prof, st_q.seg, 4'h0};
            end else if (APB_PADDR_IN == RSPS_OFF_IRQ_STAT) begin
                st_d.prdata = {28'h0000000, st_q.irq_stat};
            end else if (APB_PADDR_IN == RSPS_OFF_IRQ_MASK) begin
                st_d.prdata = {28'h0000000, st_q.irq_mask};
            end else if (APB_PADDR_IN == RSPS_OFF_SP) begin
                st_d.prdata = {16'h0000, st_q.sp};
            end else if (APB_PADDR_IN == RSPS_OFF_ELAPSED) begin
                st_d.prdata = {20'h00000, st_q.elapsed};
            end else if (seg_win && APB_PADDR_IN[1:0] == 2'h0) begin
                st_d.prdata = 32'h00000000;
            end else begin
                st_d.slverr = 1'b1;
            end
        end

        if (wr_acc && !st_q.slverr) begin
            if (APB_PADDR_IN == RSPS_OFF_CTRL) begin
                st_d.ctl_auto = APB_PWDATA_IN[RSPS_CTRL_AUTO];
                st_d.ctl_pen  = APB_PWDATA_IN[RSPS_CTRL_PEN];
                st_d.ctl_run  = APB_PWDATA_IN[RSPS_CTRL_RUN];
                st_d.sel      = APB_PWDATA_IN[RSPS_CTRL_SEL +: 3];
            end else if (APB_PADDR_IN == RSPS_OFF_TOL) begin
                st_d.tol = APB_PWDATA_IN[15:0];
            end else if (APB_PADDR_IN == RSPS_OFF_LINK) begin
                st_d.link = APB_PWDATA_IN[20:0];
            end else if (APB_PADDR_IN == RSPS_OFF_ALCFG) begin
                st_d.alcfg = APB_PWDATA_IN[3:0];
            end else if (APB_PADDR_IN == RSPS_OFF_IRQ_STAT) begin
                w1c = APB_PWDATA_IN[3:0];
            end else if (APB_PADDR_IN == RSPS_OFF_IRQ_MASK) begin
                st_d.irq_mask = APB_PWDATA_IN[3:0];
            end
        end

        st_d.hold = 1'b0;
        case (st_q.mode)
            ST_IDLE: begin
                if (go) begin
                    st_d.prof  = st_q.sel - 3'h1;
                    st_d.seg   = 3'h0;
                    st_d.chain = 1'b0;
                    st_d.mode  = ST_LOAD_INIT;
                end
            end
            ST_LOAD_INIT: begin
                st_d.mode = ST_INIT_W;
            end
            ST_INIT_W: begin
                st_d.start_sp = rd_seg.sp;
                st_d.sp       = rd_seg.sp;
                st_d.below    = $signed(PV_IN) < $signed(rd_seg.sp);
                // A chained profile starts at once without waiting for the process
                st_d.mode     = st_q.chain ? ST_LOAD_SEG : ST_WAIT_PV;
            end
            ST_WAIT_PV: begin
                st_d.sp = st_q.start_sp;
                if (reached) begin
                    st_d.mode = ST_LOAD_SEG;
                end
            end
            ST_LOAD_SEG: begin
                st_d.mode = ST_SEG_W;
            end
            ST_SEG_W: begin
                if (st_q.seg == RSPS_INIT_IDX || rd_seg.dur == 12'h000) begin
                    ev[RSPS_IRQ_PROG_END] = 1'b1;
                    if (linkv != RSPS_NO_LINK) begin
                        st_d.prof  = linkv - 3'h1;
                        st_d.seg   = 3'h0;
                        st_d.chain = 1'b1;
                        st_d.mode  = ST_LOAD_INIT;
                        ev[RSPS_IRQ_CHAIN] = 1'b1;
                    end else begin
                        st_d.ctl_run = 1'b0;
                        st_d.mode    = ST_IDLE;
                    end
                end else begin
                    st_d.cur     = rd_seg;
                    st_d.elapsed = 12'h000;
                    st_d.mode    = ST_RUN;
                end
            end
            ST_RUN: begin
                st_d.hold = hold_now;
                ev[RSPS_IRQ_HOLD] = hold_now && !st_q.hold;
                st_d.sp = ramp_point(st_q.start_sp, st_q.cur.sp, st_q.elapsed,
                                     st_q.cur.dur);
                if (PWR_FAIL_IN) begin
                    st_d.mode = ST_PFAIL;
                end else if (tick && !hold_now) begin
                    if (nxt >= st_q.cur.dur) begin
                        ev[RSPS_IRQ_SEG_DONE] = 1'b1;
                        st_d.start_sp = st_q.cur.sp;
                        st_d.seg      = st_q.seg + 3'h1;
                        st_d.mode     = ST_LOAD_SEG;
                    end else begin
                        st_d.elapsed = nxt;
                    end
                end
            end
            ST_PFAIL: begin
                if (!PWR_FAIL_IN) begin
                    st_d.elapsed = 12'h000;
                    st_d.sp      = st_q.start_sp;
                    st_d.mode    = ST_RUN;
                end
            end
            default: begin
                st_d.mode = ST_IDLE;
            end
        endcase

        if (!go && st_q.mode != ST_IDLE) begin
            st_d.mode = ST_IDLE;
        end

        st_d.alarm = (st_d.mode == ST_RUN) ? (st_d.cur.evt & st_d.alcfg) : 4'h0;
        // Hardware set wins over a same-cycle write-one-to-clear
        st_d.irq_stat = (st_q.irq_stat & ~w1c) | ev;
    end

    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            st_q      <= '0;
            st_q.mode <= ST_IDLE;
            st_q.tol  <= RSPS_TOL_RST;
            st_q.link <= RSPS_LINK_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign APB_PREADY_OUT  = 1'b1;
    assign APB_PRDATA_OUT  = st_q.prdata;
    assign APB_PSLVERR_OUT = APB_PSEL_IN && APB_PENABLE_IN && st_q.slverr;
    assign SP_OUT          = st_q.sp;
    assign CTRL_RUN_OUT    = st_q.ctl_run;
    assign PROG_ACTIVE_OUT = (st_q.mode != ST_IDLE);
    assign ALARM_OUT       = st_q.alarm;
    assign IRQ_OUT         = |(st_q.irq_stat & st_q.irq_mask);

    a_prof_range: assert property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
        st_q.mode != ST_IDLE |-> st_q.prof < 3'h7)
        else $error("Profile index out of range");
    a_seg_limit: assert property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
        st_q.mode == ST_RUN |-> st_q.seg < RSPS_INIT_IDX)
        else $error("Running beyond the seventh segment");
    a_end_run_clear: assert property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
        st_q.mode == ST_SEG_W && go && rd_seg.dur == 12'h000 && linkv == RSPS_NO_LINK
        |=> !CTRL_RUN_OUT && !PROG_ACTIVE_OUT)
        else $error("Run not cleared at end of unlinked profile");
    a_zero_dur_end: assert property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
        st_q.mode == ST_SEG_W && rd_seg.dur == 12'h000 |=> st_q.mode != ST_RUN)
        else $error("Zero duration segment was run");
    a_tol_hold: assert property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
        st_q.mode == ST_RUN && hold_now && go |=> $stable(st_q.elapsed))
        else $error("Timer advanced while out of tolerance");
    a_tol_zero_time: assert property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
        st_q.mode == ST_RUN && st_q.tol == 16'h0000 && tick && go && !PWR_FAIL_IN
        && (st_q.elapsed + 12'h001) < st_q.cur.dur
        |=> st_q.elapsed == $past(st_q.elapsed) + 12'h001)
        else $error("Timer did not advance with zero tolerance");

    a_chain_start: assert property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
        st_q.mode == ST_SEG_W && go && rd_seg.dur == 12'h000 && linkv != RSPS_NO_LINK
        |=> st_q.mode == ST_LOAD_INIT ##1 (st_q.mode == ST_INIT_W || !go)
        ##1 (st_q.mode == ST_LOAD_SEG || !go))
        else $error("Linked profile did not start at once");

    a_chain_target: assert property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
        st_q.mode == ST_SEG_W && go && rd_seg.dur == 12'h000 && linkv != RSPS_NO_LINK
        |=> st_q.prof == $past(linkv) - 3'h1 && st_q.seg == 3'h0)
        else $error("Chain went to the wrong profile");

    a_event_alarm: assert property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
        ALARM_OUT != 4'h0 |-> st_q.mode == ST_RUN && (ALARM_OUT & ~st_q.cur.evt) == 4'h0
        && (ALARM_OUT & ~st_q.alcfg) == 4'h0)
        else $error("Alarm outside its event segment");

    a_wait_pv: assert property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
        st_q.mode == ST_WAIT_PV && !reached |=> st_q.mode != ST_LOAD_SEG)
        else $error("Profile started before PV reached initial SP");

    a_pfail_resume: assert property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
        st_q.mode == ST_PFAIL && !PWR_FAIL_IN && go
        |=> st_q.mode == ST_RUN && st_q.elapsed == 12'h000 && SP_OUT == st_q.start_sp)
        else $error("Segment not restarted after power return");

    a_ramp_bound: assert property (@(posedge CLK_SYS_IN) disable iff (!ARST_N_IN)
        st_q.mode == ST_RUN && $past(st_q.mode) == ST_RUN && st_q.cur.dur != 12'h000
        |-> abs_diff(SP_OUT, st_q.cur.sp) <= abs_diff(st_q.start_sp, st_q.cur.sp))
        else $error("Setpoint left the ramp span");
endmodule : rsps_top

// ### tb/rsps_top_tb.sv
// Self-checking bench for the profile sequencer: APB set-up, runs, holds, chains.
// Assumes zero-wait APB slave and a shortened time base of TICK cycles.
`timescale 1ns/1ps
module rsps_top_tb import rsps_pkg::*;;
    localparam int TICK = 4;
    logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, pfail = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q, q2;
    logic        pready, pslverr, run, act, irq, e;
    logic [15:0] pv = 0, sp, sp_a, sp_b, last_sp;
    logic [3:0]  alarm;
    int          errors = 0, samples_checked = 0, n;
    bit          saw_al;
    rsps_top #(.TICK_CYCLES(TICK)) rsps_top_i (.CLK_SYS_IN(clk), .ARST_N_IN(rst_n),
        .APB_PSEL_IN(psel), .APB_PENABLE_IN(pen), .APB_PWRITE_IN(pwr), .APB_PADDR_IN(paddr),
        .APB_PWDATA_IN(pwdata), .APB_PREADY_OUT(pready), .APB_PRDATA_OUT(prdata),
        .APB_PSLVERR_OUT(pslverr), .PV_IN(pv), .PWR_FAIL_IN(pfail), .SP_OUT(sp),
        .CTRL_RUN_OUT(run), .PROG_ACTIVE_OUT(act), .ALARM_OUT(alarm), .IRQ_OUT(irq));
    always #20 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    // Each transfer starts after an edge so a release and a new setup never share a step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1;
        // Wait as long as the slave stretches the access; only the watchdog ends a hang
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata; e = pslverr; psel <= 0; pen <= 0;
    endtask : apb
    function automatic logic [11:0] seg_a(input int p, input int w);
        return 12'h100 + 12'((p * 8 + w) * 4);
    endfunction : seg_a
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask : cyc
    task automatic wait_end(input bit track);
        n = 0;
        while (run === 1'b1 && n < 600) begin
            @(posedge clk);
            n++;
            if (track) pv <= sp;
            if (act === 1'b1) last_sp = sp;
            if (alarm !== 4'h0) saw_al = 1;
            if (alarm !== 4'h0) chk({28'h0, alarm}, 32'h5, "event alarm");
            if (act === 1'b1) chk(32'(sp >= sp_a && sp <= sp_b), 32'h1, "ramp range");
        end
        chk(32'(n < 600), 32'h1, "run ended in time");
    endtask : wait_end
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    initial begin
        #(40 * 20000);
        errors++;
        print_verdict();
    end
    initial begin
        void'($urandom(23));
        sp_a = 16'(100 + $urandom % 400);
        sp_b = sp_a + 16'(200 + $urandom % 300);
        cyc(16);
        rst_n <= 1;
        apb(0, 12'h800, 0);
        chk({31'h0, e}, 32'h1, "unmapped err");
        chk(q, 32'h0, "unmapped data");
        apb(1, seg_a(0, 7), {16'h0, sp_a});
        apb(1, seg_a(0, 0), {4'h5, 12'h2, sp_b});
        apb(1, seg_a(0, 1), {4'h0, 12'h1, sp_b});
        apb(1, seg_a(0, 2), 32'h0);
        apb(1, seg_a(1, 7), {16'h0, sp_a});
        apb(1, seg_a(1, 0), {4'h0, 12'h6, sp_a});
        apb(1, seg_a(1, 1), 32'h0);
        apb(1, RSPS_OFF_ALCFG, 32'h7);
        apb(1, RSPS_OFF_IRQ_MASK, 32'h2);
        for (int i = 0; i < 3; i++) begin
            apb(1, RSPS_OFF_CTRL, 32'h10 | (32'h7 ^ (32'h1 << i)));
            cyc(10);
            chk({31'h0, act}, 32'h0, "partial enable");
        end
        $display("test enables done");
        apb(1, RSPS_OFF_CTRL, 32'h17);
        cyc(30);
        chk({31'h0, act}, 32'h1, "waiting active");
        chk({16'h0, sp}, {16'h0, sp_a}, "initial sp");
        apb(0, RSPS_OFF_STATUS, 0);
        chk({29'h0, q[14:12]}, 32'h3, "wait state");
        pv <= sp_a;
        saw_al = 0;
        wait_end(0);
        cyc(2);
        chk({31'h0, saw_al}, 32'h1, "alarm seen");
        chk({16'h0, last_sp}, {16'h0, sp_b}, "final sp");
        chk({30'h0, act, run}, 32'h0, "stop at end");
        chk({31'h0, irq}, 32'h1, "end irq");
        apb(1, RSPS_OFF_IRQ_STAT, 32'h2);
        cyc(1);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        $display("test time-only run done");
        apb(1, RSPS_OFF_TOL, 32'ha);
        apb(1, RSPS_OFF_CTRL, 32'h17);
        cyc(80);
        apb(0, RSPS_OFF_STATUS, 0);
        chk({31'h0, q[11]}, 32'h1, "hold flag");
        apb(0, RSPS_OFF_ELAPSED, 0);
        q2 = q;
        cyc(20);
        apb(0, RSPS_OFF_ELAPSED, 0);
        chk(q, q2, "timer frozen");
        wait_end(1);
        chk({30'h0, act, run}, 32'h0, "resumed to end");
        $display("test tolerance done");
        apb(1, RSPS_OFF_TOL, 32'h0);
        apb(1, RSPS_OFF_LINK, 32'h10);
        // Back at the initial setpoint, so the first start does not wait on PV
        pv <= sp_a;
        apb(1, RSPS_OFF_CTRL, 32'h27);
        cyc(150);
        chk({30'h0, act, run}, 32'h3, "self link loops");
        apb(0, RSPS_OFF_STATUS, 0);
        chk({31'h0, q[10]}, 32'h1, "chained flag");
        n = 0;
        do begin apb(0, RSPS_OFF_ELAPSED, 0); n++; end while (q < 3 && n < 40);
        chk(32'(q >= 3), 32'h1, "elapsed reached");
        pfail <= 1;
        cyc(20);
        apb(0, RSPS_OFF_STATUS, 0);
        chk({29'h0, q[14:12]}, 32'h7, "outage state");
        pfail <= 0;
        apb(0, RSPS_OFF_ELAPSED, 0);
        chk(32'(q <= 1), 32'h1, "segment restarted");
        apb(1, RSPS_OFF_CTRL, 32'h0);
        cyc(2);
        chk({27'h0, alarm, act}, 32'h0, "go dropped");
        $display("test chain and outage done");
        print_verdict();
    end
endmodule : rsps_top_tb
